// [logic/fpc_pkg.sv]
// Package for the front-panel alarm and test-control block.
// Assumes a 40 MHz system clock; shared by the top and its debounce leaf.
package fpc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 40000000;
	localparam int unsigned LAMP_TEST_S     = 30;
	localparam longint unsigned LAMP_TEST_CYC = longint'(LAMP_TEST_S) * longint'(CLK_HZ);
	localparam int unsigned DEBOUNCE_US     = 10000;
	localparam int unsigned DEBOUNCE_CYC    = (DEBOUNCE_US * (CLK_HZ / 1000000));
	localparam int unsigned ACT_HOLD_US     = 50000;
	localparam int unsigned ACT_HOLD_CYC    = (ACT_HOLD_US * (CLK_HZ / 1000000));
	localparam int unsigned RESET_HOLD_CYC  = 16;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_LAMPS  = 4'h8;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Control register fields
	localparam int unsigned CTRL_SELFCHK_OK = 0;
	localparam int unsigned CTRL_SELFCHK_BAD = 1;
	localparam int unsigned CTRL_RTC_FAIL   = 2;
	localparam int unsigned CTRL_ID_BAD     = 3;
	localparam int unsigned CTRL_DL_FAIL    = 4;
	localparam int unsigned CTRL_W          = 5;

	// Number of debounced switch lines: level 1/0, line far/near, data far/near, reset
	localparam int unsigned NSW = 7;

	typedef struct packed {
		logic lfa;
		logic los;
		logic ais;
		logic ber_high;
		logic rai;
		logic carrier_ok;
	} fpc_line_s;

	typedef struct packed {
		logic local_alarm_lamp;
		logic far_end_alarm_lamp;
		logic rts_lamp;
		logic cts_lamp;
		logic cd_lamp;
		logic dsr_lamp;
		logic line_tx_lamp;
		logic line_rx_lamp;
		logic link_lamp;
		logic network_activity_lamp;
		logic test_lamp;
		logic loop_lamp;
	} fpc_lamps_s;

	typedef struct packed {
		logic local_line_loop;
		logic remote_line_loop;
		logic local_data_loop;
		logic remote_data_loop;
		logic send_level_en;
		logic send_level;
	} fpc_test_s;

endpackage

// [logic/fpc_debounce.sv]
// Two-flop synchroniser plus stability counter for one bank of switch lines.
// Assumes raw asynchronous contact inputs; output changes only after DEBOUNCE_CYC stable cycles.
`timescale 1ns/1ps
`default_nettype none
module fpc_debounce #(
	parameter int unsigned DEBOUNCE_CYC = fpc_pkg::DEBOUNCE_CYC
) (
	input  wire logic                     clk_sys_i,
	input  wire logic                     rst_n_i,
	input  wire logic [fpc_pkg::NSW-1:0]  raw_i,
	output logic      [fpc_pkg::NSW-1:0]  clean_o
);
	typedef struct packed {
		logic [fpc_pkg::NSW-1:0] s1;
		logic [fpc_pkg::NSW-1:0] s2;
		logic [fpc_pkg::NSW-1:0] clean;
		logic [fpc_pkg::NSW-1:0][18:0] cnt;
	} fpc_db_s;

	fpc_db_s st_ff;
	fpc_db_s nxt_st;

	// ----------------------------------------------------------------
	// Per-line stability counters
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = raw_i;
		nxt_st.s2 = st_ff.s1;
		for (int i = 0; i < int'(fpc_pkg::NSW); i++) begin
			if (st_ff.s2[i] == st_ff.clean[i]) begin
				nxt_st.cnt[i] = '0;
			end else if (st_ff.cnt[i] == 19'(DEBOUNCE_CYC - 1)) begin
				nxt_st.clean[i] = st_ff.s2[i];
				nxt_st.cnt[i]   = '0;
			end else begin
				nxt_st.cnt[i] = st_ff.cnt[i] + 19'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign clean_o = st_ff.clean;

	// Clean output moves only after a full stable window
	property p_db_stable;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(st_ff.clean != $past(st_ff.clean)) |-> ($past(st_ff.cnt) != '0);
	endproperty
	a_db_stable: assert property (p_db_stable) else $error("debounced switch changed without a stable window");
endmodule
`default_nettype wire

// [logic/fpc_front_panel.sv]
// Front-panel lamp, alarm, loop and test-switch control with an AXI4-Lite register port.
// Assumes line framer, V.24 and LAN status arrive on clk_sys_i except the panel switches,
// line/terminal activity pins, which are asynchronous and synchronised here.
// What this block does
// - All lamps lit thirty seconds at power-up; all lamps, not only loop and alarm, stay lit until self-check reports.
// - Local alarm lamp on for self-check, RTC, ID, link, LFA, LOS, AIS, BER faults.
// - Far-end alarm lamp covers none of these causes, excessive bit error ratio included.
// - Far-end alarm comes only from the received frame's remote alarm bit.
// - Request-to-send lamp follows the terminal RTS circuit, and is also lit while local data loop forces RTS.
// - Clear-to-send lamp follows the CTS the device drives.
// - Carrier-detect lamp lit while received carrier exceeds the preset threshold.
// - Modem-ready lamp shows the DSR circuit.
// - Line transmit and receive activity lamps show traffic on line input and output.
// - Link lamp shows LAN link up; activity lamp shows any LAN traffic.
// - Test lamp lit while a test level is sent to the V.24 side.
// - Level switch at one sends continuous one; at zero sends continuous zero.
// - Loop lamp lit while any line or data loop is active.
// - Line switch far position selects remote line loop, near selects local.
// - Data switch far position selects remote data loop, near selects local.
// - Reset push-button resets the whole equipment.
// - Local line loop returns internal transmit frame; remote returns line frame outward.
// - Remote data loop joins TD to RD; local data loop holds RTS active.
// - DSR deasserted while any loop or test transmission is active.
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fpc_front_panel #(
	parameter longint unsigned LAMP_TEST_CYC = fpc_pkg::LAMP_TEST_CYC,
	parameter int unsigned     DEBOUNCE_CYC  = fpc_pkg::DEBOUNCE_CYC
) (
	input  wire logic                  clk_sys_i,
	input  wire logic                  rst_n_i,
	// AXI4-Lite slave
	input  wire logic [3:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [3:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// Status from line framer, same clock
	input  wire fpc_pkg::fpc_line_s    line_i,
	// V.24 circuits and LAN status, same clock
	input  wire logic                  rts_i,
	input  wire logic                  cts_i,
	input  wire logic                  lan_link_i,
	input  wire logic                  lan_tx_act_i,
	input  wire logic                  lan_rx_act_i,
	// Line data pins, asynchronous
	input  wire logic                  line_data_in_i,
	input  wire logic                  line_data_out_i,
	// Panel switches and push-button, asynchronous, active low
	input  wire logic                  sw_level_one_n_i,
	input  wire logic                  sw_level_zero_n_i,
	input  wire logic                  sw_line_far_position_n_i,
	input  wire logic                  sw_line_near_position_n_i,
	input  wire logic                  sw_data_far_position_n_i,
	input  wire logic                  sw_data_near_position_n_i,
	input  wire logic                  reset_button_n_i,
	output fpc_pkg::fpc_lamps_s        lamps_o,
	output fpc_pkg::fpc_test_s         test_o,
	output logic                       rts_forced_o,
	output logic                       dsr_o,
	output logic                       equip_reset_n_o
);
	typedef struct packed {
		logic                          awready;
		logic                          wready;
		logic                          bvalid;
		logic [1:0]                    bresp;
		logic                          arready;
		logic                          rvalid;
		logic [1:0]                    rresp;
		logic [31:0]                   rdata;
		logic [fpc_pkg::CTRL_W-1:0]    ctrl;
		logic                          selfchk_done;
		logic [35:0]                   pwr_cnt;
		logic                          lamp_test;
		logic [1:0]                    din_s;
		logic [1:0]                    dout_s;
		logic                          din_prev;
		logic                          dout_prev;
		logic [20:0]                   tx_hold;
		logic [20:0]                   rx_hold;
		logic [20:0]                   lan_hold;
		logic [4:0]                    rst_cnt;
		logic                          equip_rst_n;
		fpc_pkg::fpc_lamps_s           lamps;
		fpc_pkg::fpc_test_s            test;
		logic                          rts_forced;
		logic                          dsr;
	} fpc_top_s;

	fpc_top_s st_ff;
	fpc_top_s nxt_st;
	logic [fpc_pkg::NSW-1:0] sw_clean;
	logic local_alarm;
	logic far_alarm;
	logic any_loop;

	// ----------------------------------------------------------------
	// Switch synchroniser and debounce
	// ----------------------------------------------------------------
	fpc_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) fpc_debounce_i (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.raw_i     ({~reset_button_n_i, ~sw_data_near_position_n_i, ~sw_data_far_position_n_i,
		             ~sw_line_near_position_n_i, ~sw_line_far_position_n_i,
		             ~sw_level_zero_n_i, ~sw_level_one_n_i}),
		.clean_o   (sw_clean)
	);

	// Activity hold: retrigger on event, else count down
	function automatic logic [20:0] hold_next(input logic ev, input logic [20:0] cur);
		if (ev) begin
			hold_next = 21'(fpc_pkg::ACT_HOLD_CYC);
		end else if (cur != '0) begin
			hold_next = cur - 21'h1;
		end else begin
			hold_next = '0;
		end
	endfunction

	// Alarm cause combination
	assign local_alarm = st_ff.ctrl[fpc_pkg::CTRL_SELFCHK_BAD] | st_ff.ctrl[fpc_pkg::CTRL_RTC_FAIL]
	                   | st_ff.ctrl[fpc_pkg::CTRL_ID_BAD] | st_ff.ctrl[fpc_pkg::CTRL_DL_FAIL]
	                   | line_i.lfa | line_i.los | line_i.ais | line_i.ber_high;
	assign far_alarm   = line_i.rai;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		any_loop = 1'b0;

		// Register write: address and data taken together, response raised in the same cycle
		nxt_st.awready = 1'b0;
		nxt_st.wready  = 1'b0;
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		if (s_axi_awvalid && s_axi_wvalid && !st_ff.bvalid && !st_ff.awready) begin
			nxt_st.awready = 1'b1;
			nxt_st.wready  = 1'b1;
			nxt_st.bvalid  = 1'b1;
			nxt_st.bresp   = fpc_pkg::RESP_OKAY;
			if (s_axi_awaddr == fpc_pkg::ADDR_CTRL) begin
				if (s_axi_wstrb[0]) begin
					nxt_st.ctrl = s_axi_wdata[fpc_pkg::CTRL_W-1:0];
				end
			end else begin
				nxt_st.bresp = fpc_pkg::RESP_SLVERR;
			end
		end

		// Register read
		nxt_st.arready = 1'b0;
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !st_ff.rvalid && !st_ff.arready) begin
			nxt_st.arready = 1'b1;
			nxt_st.rvalid  = 1'b1;
			nxt_st.rresp   = fpc_pkg::RESP_OKAY;
			case (s_axi_araddr)
				fpc_pkg::ADDR_CTRL: begin
					nxt_st.rdata = 32'(st_ff.ctrl);
				end
				fpc_pkg::ADDR_STATUS: begin
					nxt_st.rdata = 32'({st_ff.lamp_test, st_ff.selfchk_done, st_ff.test});
				end
				fpc_pkg::ADDR_LAMPS: begin
					nxt_st.rdata = 32'(st_ff.lamps);
				end
				default: begin
					nxt_st.rdata = '0;
					nxt_st.rresp = fpc_pkg::RESP_SLVERR;
				end
			endcase
		end

		// Power-up lamp test lasts the full period and until self-check reports
		if (st_ff.ctrl[fpc_pkg::CTRL_SELFCHK_OK] || st_ff.ctrl[fpc_pkg::CTRL_SELFCHK_BAD]) begin
			nxt_st.selfchk_done = 1'b1;
		end
		if (st_ff.pwr_cnt != 36'(LAMP_TEST_CYC)) begin
			nxt_st.pwr_cnt = st_ff.pwr_cnt + 36'h1;
		end
		nxt_st.lamp_test = (st_ff.pwr_cnt != 36'(LAMP_TEST_CYC)) || !st_ff.selfchk_done;

		// Activity pins: two flops then edge detect on the second
		nxt_st.din_s     = {st_ff.din_s[0], line_data_in_i};
		nxt_st.dout_s    = {st_ff.dout_s[0], line_data_out_i};
		nxt_st.din_prev  = st_ff.din_s[1];
		nxt_st.dout_prev = st_ff.dout_s[1];
		nxt_st.tx_hold   = hold_next(st_ff.din_s[1] ^ st_ff.din_prev, st_ff.tx_hold);
		nxt_st.rx_hold   = hold_next(st_ff.dout_s[1] ^ st_ff.dout_prev, st_ff.rx_hold);
		nxt_st.lan_hold  = hold_next(lan_tx_act_i | lan_rx_act_i, st_ff.lan_hold);

		// Switch decode; both ends together or centre leave the function off
		nxt_st.test.send_level_en    = sw_clean[0] ^ sw_clean[1];
		nxt_st.test.send_level       = sw_clean[0] & ~sw_clean[1];
		nxt_st.test.remote_line_loop = sw_clean[2] & ~sw_clean[3];
		nxt_st.test.local_line_loop  = sw_clean[3] & ~sw_clean[2];
		nxt_st.test.remote_data_loop = sw_clean[4] & ~sw_clean[5];
		nxt_st.test.local_data_loop  = sw_clean[5] & ~sw_clean[4];
		any_loop = st_ff.test.remote_line_loop | st_ff.test.local_line_loop
		         | st_ff.test.remote_data_loop | st_ff.test.local_data_loop;
		nxt_st.rts_forced = st_ff.test.local_data_loop;
		nxt_st.dsr        = !(any_loop || st_ff.test.send_level_en);

		// Reset push-button stretched into an equipment reset pulse
		if (sw_clean[6]) begin
			nxt_st.rst_cnt = 5'(fpc_pkg::RESET_HOLD_CYC);
		end else if (st_ff.rst_cnt != '0) begin
			nxt_st.rst_cnt = st_ff.rst_cnt - 5'h1;
		end
		nxt_st.equip_rst_n = (st_ff.rst_cnt == '0) && !sw_clean[6];

		// Lamps
		nxt_st.lamps.local_alarm_lamp      = local_alarm;
		nxt_st.lamps.far_end_alarm_lamp    = far_alarm;
		nxt_st.lamps.rts_lamp              = rts_i | st_ff.rts_forced;
		nxt_st.lamps.cts_lamp              = cts_i;
		nxt_st.lamps.cd_lamp               = line_i.carrier_ok;
		nxt_st.lamps.dsr_lamp              = st_ff.dsr;
		nxt_st.lamps.line_tx_lamp          = st_ff.tx_hold != '0;
		nxt_st.lamps.line_rx_lamp          = st_ff.rx_hold != '0;
		nxt_st.lamps.link_lamp             = lan_link_i;
		nxt_st.lamps.network_activity_lamp = st_ff.lan_hold != '0;
		nxt_st.lamps.test_lamp             = st_ff.test.send_level_en;
		nxt_st.lamps.loop_lamp             = any_loop;
		if (st_ff.lamp_test) begin
			nxt_st.lamps = '1;
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			st_ff             <= '0;
			st_ff.lamp_test   <= 1'b1;
			st_ff.lamps       <= '1;
			st_ff.dsr         <= 1'b1;
			st_ff.equip_rst_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign s_axi_awready   = st_ff.awready;
	assign s_axi_wready    = st_ff.wready;
	assign s_axi_bvalid    = st_ff.bvalid;
	assign s_axi_bresp     = st_ff.bresp;
	assign s_axi_arready   = st_ff.arready;
	assign s_axi_rvalid    = st_ff.rvalid;
	assign s_axi_rresp     = st_ff.rresp;
	assign s_axi_rdata     = st_ff.rdata;
	assign lamps_o         = st_ff.lamps;
	assign test_o          = st_ff.test;
	assign rts_forced_o    = st_ff.rts_forced;
	assign dsr_o           = st_ff.dsr;
	assign equip_reset_n_o = st_ff.equip_rst_n;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_lamp_test;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		st_ff.lamp_test |=> (lamps_o == '1);
	endproperty
	a_lamp_test: assert property (p_lamp_test) else $error("lamp test not lighting all lamps");

	property p_local_alarm;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!st_ff.lamp_test && line_i.los) |=> lamps_o.local_alarm_lamp;
	endproperty
	a_local_alarm: assert property (p_local_alarm) else $error("loss of signal did not light local alarm");

	property p_far_ber;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!st_ff.lamp_test && !line_i.rai && line_i.ber_high) |=> !lamps_o.far_end_alarm_lamp;
	endproperty
	a_far_ber: assert property (p_far_ber) else $error("BER alone lit far-end alarm");

	property p_far_rai;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!st_ff.lamp_test |=> (lamps_o.far_end_alarm_lamp == $past(line_i.rai));
	endproperty
	a_far_rai: assert property (p_far_rai) else $error("far-end lamp differs from remote alarm bit");

	property p_cts;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!st_ff.lamp_test |=> (lamps_o.cts_lamp == $past(cts_i));
	endproperty
	a_cts: assert property (p_cts) else $error("clear-to-send lamp wrong");

	property p_dsr_loop;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(test_o.local_line_loop || test_o.remote_line_loop || test_o.local_data_loop
		 || test_o.remote_data_loop || test_o.send_level_en) |=> !dsr_o;
	endproperty
	a_dsr_loop: assert property (p_dsr_loop) else $error("DSR active during loop or test");

	property p_loop_lamp;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!st_ff.lamp_test && test_o.remote_line_loop) |=> lamps_o.loop_lamp;
	endproperty
	a_loop_lamp: assert property (p_loop_lamp) else $error("loop lamp dark with loop active");

	property p_exclusive;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		!(test_o.local_line_loop && test_o.remote_line_loop) && !(test_o.local_data_loop && test_o.remote_data_loop);
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("near and far loops both active");

	property p_button;
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		sw_clean[6] |=> !equip_reset_n_o ##1 !equip_reset_n_o;
	endproperty
	a_button: assert property (p_button) else $error("reset button did not reset equipment");

endmodule
`default_nettype wire

// [verif/fpc_far_side_model.sv]
// Far-side stand-in: line and LAN traffic sources plus two chattering panel contacts.
// Assumes the bench enables traffic, chatter or a held press; contacts rest open (pulled high).
`timescale 1ns/1ps
`default_nettype none
module fpc_far_side_model (
	input  wire logic       clk_sys_i,
	input  wire logic       act_en_i,
	input  wire logic       bounce_en_i,
	input  wire logic [1:0] press_i,
	output logic            line_data_in_o,
	output logic            line_data_out_o,
	output logic            lan_tx_act_o,
	output logic            lan_rx_act_o,
	output logic            sw_far_n_o,
	output logic            button_n_o
);
	logic [7:0] cnt_ff = 8'h00;

	// Traffic toggles lines while enabled, quiet lines rest low; chatter never rests long enough to count
	always @(posedge clk_sys_i) begin
		cnt_ff <= cnt_ff + 8'h01;
		line_data_in_o <= act_en_i & cnt_ff[1];
		line_data_out_o <= act_en_i & ~cnt_ff[2];
		lan_tx_act_o <= act_en_i & (cnt_ff[2:0] == 3'h0);
		lan_rx_act_o <= act_en_i & (cnt_ff[2:0] == 3'h4);
		sw_far_n_o <= ~press_i[0] & (bounce_en_i ? cnt_ff[3] : 1'b1); // Open contact reads high
		button_n_o <= ~press_i[1] & (bounce_en_i ? cnt_ff[4] : 1'b1); // Press holds it closed
	end
endmodule
`default_nettype wire

// [verif/test_front_panel_alarm_test_control.sv]
// Self-checking bench for the front-panel block: register reads feed a scoreboard queue.
// Assumes the far-side model for traffic and contacts; lamp test shortened to 50 cycles, debounce to 20.
`timescale 1ns/1ps
`default_nettype none
module test_front_panel_alarm_test_control;
	logic               clk_sys_i = 1'b0;
	logic               rst_n_i = 1'b0;
	logic [3:0]         s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0]        s_axi_wdata = 32'h0, s_axi_rdata;
	logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic               s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]         s_axi_bresp, s_axi_rresp;
	fpc_pkg::fpc_line_s line_i = '0;
	logic               rts_i = 1'b0, cts_i = 1'b0, lan_link_i = 1'b0, act_en = 1'b0, bounce_en = 1'b0;
	logic [4:0]         sw_idle_n = 5'h1f;
	logic [1:0]         press = 2'h0;
	logic [5:0]         tst_x [7] = '{6'h03, 6'h02, 6'h20, 6'h04, 6'h08, 6'h10, 6'h00};
	logic               line_data_in_i, line_data_out_i, lan_tx_act_i, lan_rx_act_i, sw_far_n, button_n;
	fpc_pkg::fpc_lamps_s lamps_o, e;
	fpc_pkg::fpc_test_s test_o;
	logic               rts_forced_o, dsr_o, equip_reset_n_o;
	int                 err_total = 0, compares = 0, i, k;
	logic [31:0]        v;
	logic [33:0]        exp_q[$], msk_q[$];
	string              nm_q[$];

	fpc_front_panel #(.LAMP_TEST_CYC(50), .DEBOUNCE_CYC(20)) fpc_front_panel_i (.clk_sys_i, .rst_n_i, .s_axi_awaddr,
		.s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .line_i, .rts_i, .cts_i, .lan_link_i, .lan_tx_act_i, .lan_rx_act_i, .line_data_in_i,
		.line_data_out_i, .sw_level_one_n_i(sw_idle_n[0]), .sw_level_zero_n_i(sw_idle_n[1]),
		.sw_line_far_position_n_i(sw_far_n), .sw_line_near_position_n_i(sw_idle_n[2]),
		.sw_data_far_position_n_i(sw_idle_n[3]), .sw_data_near_position_n_i(sw_idle_n[4]),
		.reset_button_n_i(button_n), .lamps_o, .test_o, .rts_forced_o, .dsr_o, .equip_reset_n_o);

	fpc_far_side_model fpc_far_side_model_i (.clk_sys_i, .act_en_i(act_en), .bounce_en_i(bounce_en), .press_i(press),
		.line_data_in_o(line_data_in_i), .line_data_out_o(line_data_out_i), .lan_tx_act_o(lan_tx_act_i),
		.lan_rx_act_o(lan_rx_act_i), .sw_far_n_o(sw_far_n), .button_n_o(button_n));

	// 40 MHz clock
	always #12.5 clk_sys_i = ~clk_sys_i;

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [33:0] ex, input logic [33:0] got);
		compares++;
		if (got !== ex) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	// Write with both channels offered together; expectation is the response code
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		nm_q.push_back("bresp");
		exp_q.push_back({r, 32'h0});
		msk_q.push_back({2'h3, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_sys_i);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		s_axi_bready <= 1'b0;
		@(posedge clk_sys_i); // Gap edge keeps back-to-back calls apart
		if (n == 100) begin
			err_total++;
			stop_test();
		end
	endtask

	// Read; only the bits under the mask are compared
	task automatic axi_rd(input logic [3:0] a, input logic [1:0] r, input logic [31:0] ex, input logic [31:0] mk);
		int n;
		nm_q.push_back($sformatf("read %h", a));
		exp_q.push_back({r, ex & mk});
		msk_q.push_back({2'h3, mk});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_sys_i);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		s_axi_rready <= 1'b0;
		@(posedge clk_sys_i); // Gap edge keeps back-to-back calls apart
		if (n == 100) begin
			err_total++;
			stop_test();
		end
	endtask

	// Scoreboard: each completed response is matched with the oldest note
	always @(posedge clk_sys_i) begin
		if ((s_axi_rvalid === 1'b1 && s_axi_rready) || (s_axi_bvalid === 1'b1 && s_axi_bready)) begin
			if (exp_q.size() == 0)
				chk("unexpected response", 34'h0, 34'h3ffffffff);
			else
				chk(nm_q.pop_front(), exp_q.pop_front(), msk_q.pop_front() &
					(s_axi_rvalid === 1'b1 ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0}));
		end
	end

	// Hang guard
	initial begin
		tick(100000);
		err_total++;
		stop_test();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(17450));
		tick(12);
		rst_n_i <= 1'b1;
		axi_rd(fpc_pkg::ADDR_LAMPS, fpc_pkg::RESP_OKAY, 32'hfff, 32'hffffffff);
		axi_rd(fpc_pkg::ADDR_STATUS, fpc_pkg::RESP_OKAY, 32'h80, 32'hff);
		chk("test_o", 34'h0, 34'(test_o));
		tick(60);
		axi_rd(fpc_pkg::ADDR_STATUS, fpc_pkg::RESP_OKAY, 32'h80, 32'hff);
		axi_wr(fpc_pkg::ADDR_CTRL, 32'h1, fpc_pkg::RESP_OKAY);
		tick(3);
		axi_rd(fpc_pkg::ADDR_STATUS, fpc_pkg::RESP_OKAY, 32'h40, 32'hff);
		$display("test lamp_test done");
		// Each alarm cause in turn: five line causes, then four control causes
		for (k = 0; k < 9; k++) begin
			if (k < 5) line_i <= 6'(6'h20 >> k);
			else axi_wr(fpc_pkg::ADDR_CTRL, 32'h1 | (32'h1 << (k - 4)), fpc_pkg::RESP_OKAY);
			tick(3);
			e = '0;
			e.local_alarm_lamp = (k != 4);
			e.far_end_alarm_lamp = (k == 4);
			axi_rd(fpc_pkg::ADDR_LAMPS, fpc_pkg::RESP_OKAY, 32'(e), 32'hc00);
			line_i <= '0;
			axi_wr(fpc_pkg::ADDR_CTRL, 32'h1, fpc_pkg::RESP_OKAY);
		end
		$display("test alarms done");
		// Random handshake and link levels
		for (i = 0; i < 8; i++) begin
			v = $urandom;
			rts_i <= v[0];
			cts_i <= v[1];
			line_i.carrier_ok <= v[2];
			lan_link_i <= v[3];
			tick(3);
			e = '0;
			e.rts_lamp = v[0];
			e.cts_lamp = v[1];
			e.cd_lamp = v[2];
			e.dsr_lamp = 1'b1;
			e.link_lamp = v[3];
			axi_rd(fpc_pkg::ADDR_LAMPS, fpc_pkg::RESP_OKAY, 32'(e), 32'hfcb);
			chk("dsr_o", 34'h1, {33'h0, dsr_o});
		end
		$display("test levels done");
		act_en <= 1'b1;
		tick(40);
		act_en <= 1'b0;
		axi_rd(fpc_pkg::ADDR_LAMPS, fpc_pkg::RESP_OKAY, 32'h34, 32'h34);
		$display("test activity done");
		// Each contact closed in turn, then both ends of the line switch together
		rts_i <= 1'b0;
		for (k = 0; k < 7; k++) begin
			sw_idle_n <= (k < 5) ? ~(5'h1 << k) : ((k == 6) ? 5'h1b : 5'h1f);
			press <= {1'b0, k > 4};
			tick(40);
			v = 32'(tst_x[k]);
			chk("test_o", 34'(v), 34'(test_o));
			chk("dsr_o", {33'h0, ~|v[5:1]}, {33'h0, dsr_o});
			chk("rts_forced_o", {33'h0, v[3]}, {33'h0, rts_forced_o});
			axi_rd(fpc_pkg::ADDR_LAMPS, fpc_pkg::RESP_OKAY, {22'h0, v[3], 2'h0, ~|v[5:1], 4'h0, v[1], |v[5:2]},
				32'h243);
		end
		// Held push-button drives the equipment reset, which ends after release
		sw_idle_n <= 5'h1f;
		press <= 2'h2;
		tick(40);
		chk("equip_reset_n_o", 34'h0, {33'h0, equip_reset_n_o});
		press <= 2'h0;
		tick(60);
		chk("equip_reset_n_o", 34'h1, {33'h0, equip_reset_n_o});
		chk("test_o", 34'h0, 34'(test_o));
		$display("test switches done");
		// Contact chatter must never reach loop state or the equipment reset
		bounce_en <= 1'b1;
		for (i = 0; i < 20; i++) begin
			tick(100);
			chk("test_o", 34'h0, 34'(test_o));
			chk("equip_reset_n_o", 34'h1, {33'h0, equip_reset_n_o});
			chk("dsr_o", 34'h1, {33'h0, dsr_o});
		end
		bounce_en <= 1'b0;
		$display("test chatter done");
		axi_rd(4'hc, fpc_pkg::RESP_SLVERR, 32'h0, 32'hffffffff);
		axi_wr(fpc_pkg::ADDR_STATUS, 32'hff, fpc_pkg::RESP_SLVERR);
		axi_wr(4'hc, 32'hff, fpc_pkg::RESP_SLVERR);
		axi_wr(fpc_pkg::ADDR_CTRL, 32'hffffffe1, fpc_pkg::RESP_OKAY);
		s_axi_wstrb <= 4'he;
		axi_wr(fpc_pkg::ADDR_CTRL, 32'h1e, fpc_pkg::RESP_OKAY); // Low byte strobe off: no write
		s_axi_wstrb <= 4'hf;
		axi_rd(fpc_pkg::ADDR_CTRL, fpc_pkg::RESP_OKAY, 32'h1, 32'hffffffff);
		axi_rd(fpc_pkg::ADDR_STATUS, fpc_pkg::RESP_OKAY, 32'h40, 32'hff);
		$display("test registers done");
		for (i = 0; i < 100 && exp_q.size() != 0; i++) tick(1);
		if (exp_q.size() != 0) err_total++;
		stop_test();
	end
endmodule
`default_nettype wire
